//--- rtl/prfw_pkg.sv
// package for the region freeze wrapper: widths, reset values, timing counts
// assumes a single 200 MHz system clock drives every register of the block
package prfw_pkg;

  // =========================================================================
  // widths
  localparam int unsigned MODE_W      = 4;
  localparam int unsigned FRAMER_W    = 4;
  localparam int unsigned REGION_W    = 16;
  localparam int unsigned LOAD_W      = 16;
  localparam int unsigned MAX_GLOBALS = 6;

  // =========================================================================
  // freeze and reset values
  localparam logic [MODE_W-1:0]   MODE_FROZEN   = 4'hF;
  localparam logic [FRAMER_W-1:0] FRAMER_FROZEN = 4'hF;
  localparam logic                CLOCK_PARKED  = 1'b1;
  localparam logic [REGION_W-1:0] OUT_SAFE      = 16'h0000;

  // =========================================================================
  // handshake timing, in clk_sys cycles
  localparam logic [3:0] READY_GAP_CYCLES = 4'h4;
  localparam logic [3:0] DROP_CYCLES      = 4'h8;

  // =========================================================================
  // control block states
  typedef enum logic [2:0] {
    PRFW_IDLE  = 3'b000,
    PRFW_INIT  = 3'b001,
    PRFW_GAP   = 3'b010,
    PRFW_LOAD  = 3'b011,
    PRFW_DONE  = 3'b100
  } prfw_state_type;

endpackage

//--- rtl/prfw_freeze_reg.sv
// one registered, freezable input of the reconfigurable region
// assumes din is synchronous to clk_sys; sample marks the owning clock's edge
`timescale 1ns/1ps

module prfw_freeze_reg #(
  parameter int unsigned        WIDTH  = 4,
  parameter logic [WIDTH-1:0]   FROZEN = '1
) (
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic             sample,
  input  wire logic             freeze,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] next_dout;

  // =========================================================================
  // on each owning edge load all ones while frozen, else the live value
  always_comb begin
    next_dout = dout;
    if (sample) begin
      next_dout = freeze ? FROZEN : din;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dout <= FROZEN;
    end else begin
      dout <= next_dout;
    end
  end

endmodule

//--- rtl/prfw_wrapper.sv
// freeze wrapper around a reconfigurable core plus the reconfiguration
// control handshake (request, ready, done, 16-bit load path)
// assumes all inputs are synchronous to clk_sys; local_clock is a sampled level
//
// Overview of operation
// R1: mode copy loads all ones on global edge while frozen, else live input.
// R2: framer copy loads all ones on local clock edge while frozen, else live.
// R3: clock into region is parked high while frozen, else follows local clock.
// R4: ports: 4-bit mode, 4-bit framer control, 16-bit region output bus.
// R5: region outputs optionally forced to a safe constant while frozen.
// R6: at most six global clock networks enter the region.
// R7: global networks carry only clock, async clear and memory enables.
// R8: host drives request high to ask for a reconfiguration.
// R9: ready high only when prepared to accept reconfiguration data.
// R10: done high reports the reconfiguration has completed.
// R11: pin-driven loads use the 16-bit parallel data path.
// R12: handshake pins dedicated only when pin reconfiguration enabled, else user I/O.
// R13: global signals into the region are never frozen.
// R14: host waits exactly four cycles after ready before first data word.
// R15: host drops request within eight cycles of done, else a new cycle starts.
// R16: host freezes before request and releases after all regions are done.
// R17: async clear passes to the region unchanged regardless of freeze.
`timescale 1ns/1ps

module prfw_wrapper
  import prfw_pkg::*;
#(
  parameter int unsigned GLOBAL_NETS    = 2,
  parameter int unsigned INIT_CYCLES    = 8,
  parameter int unsigned LOAD_WORDS     = 16,
  parameter logic        FORCE_OUTPUTS  = 1'b1
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  input  wire logic                   freeze,
  input  wire logic                   local_clock,
  input  wire logic                   async_clear,
  input  wire logic [GLOBAL_NETS-1:0] global_clock_net,
  input  wire logic [MODE_W-1:0]      control_mode,
  input  wire logic [FRAMER_W-1:0]    framer_ctl,
  input  wire logic [REGION_W-1:0]    core_out,
  output logic                        gated_local_clock,
  output logic                        core_async_clear,
  output logic [MAX_GLOBALS-1:0]      core_global_net,
  output logic [MODE_W-1:0]           core_mode,
  output logic [FRAMER_W-1:0]         core_framer,
  output logic [REGION_W-1:0]         data_out,
  input  wire logic                   pins_enable,
  input  wire logic                   pin_request,
  input  wire logic                   core_request,
  input  wire logic                   pin_ready_user,
  input  wire logic                   pin_done_user,
  output logic                        pin_request_user,
  output logic                        reconfig_ready,
  output logic                        reconfig_done,
  output logic                        pin_ready,
  output logic                        pin_done,
  input  wire logic [LOAD_W-1:0]      parallel_x16_load,
  input  wire logic                   load_valid,
  output logic [LOAD_W-1:0]           load_word,
  output logic                        load_strobe
);

  // =========================================================================
  // global networks: at most six pass, none frozen
  localparam int unsigned GLOBALS_PASSED = (GLOBAL_NETS > MAX_GLOBALS) ? MAX_GLOBALS : GLOBAL_NETS;

  always_comb begin
    core_global_net = '0;
    for (int i = 0; i < GLOBALS_PASSED; i++) begin
      core_global_net[i] = global_clock_net[i];  // [R6] [R13]
    end
  end

  // async clear is a global input, only carried unchanged
  assign core_async_clear = async_clear;  // [R17] [R7]

  // park the region's local clock while frozen
  assign gated_local_clock = freeze ? CLOCK_PARKED : local_clock;  // [R3]

  // =========================================================================
  // freezable inputs
  logic local_prev;
  logic next_local_prev;
  logic local_rise;

  // local clock edge found from the previous sample
  always_comb begin
    next_local_prev = local_clock;
    local_rise      = local_clock & ~local_prev;
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      local_prev <= 1'b0;
    end else begin
      local_prev <= next_local_prev;
    end
  end

  // mode copy follows the global clock, every edge
  prfw_freeze_reg #(
    .WIDTH  (MODE_W),
    .FROZEN (MODE_FROZEN)
  ) u_mode (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .sample  (1'b1),
    .freeze  (freeze),
    .din     (control_mode),
    .dout    (core_mode)
  );  // [R1] [R4]

  // framer copy follows the local clock edge
  prfw_freeze_reg #(
    .WIDTH  (FRAMER_W),
    .FROZEN (FRAMER_FROZEN)
  ) u_framer (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .sample  (local_rise),
    .freeze  (freeze),
    .din     (framer_ctl),
    .dout    (core_framer)
  );  // [R2] [R4]

  // =========================================================================
  // region output bus, forced safe while frozen when enabled
  logic [REGION_W-1:0] next_data_out;

  always_comb begin
    next_data_out = (freeze && FORCE_OUTPUTS) ? OUT_SAFE : core_out;  // [R5]
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      data_out <= OUT_SAFE;
    end else begin
      data_out <= next_data_out;
    end
  end

  // =========================================================================
  // control block handshake
  prfw_state_type state;
  prfw_state_type next_state;
  logic [15:0]    count;
  logic [15:0]    next_count;
  logic           request;
  logic           next_ready;
  logic           next_done;
  logic [LOAD_W-1:0] next_load_word;
  logic           next_load_strobe;

  // request source: dedicated pin or core logic
  always_comb begin
    request          = pins_enable ? pin_request : core_request;  // [R8] [R12]
    pin_request_user = pins_enable ? 1'b0 : pin_request;  // [R12]
    pin_ready        = pins_enable ? reconfig_ready : pin_ready_user;  // [R12]
    pin_done         = pins_enable ? reconfig_done : pin_done_user;  // [R12]
  end

  // sequence: init, three-cycle gap, word load, done with drop window
  always_comb begin
    next_state       = state;
    next_count       = count;
    next_ready       = reconfig_ready;
    next_done        = reconfig_done;
    next_load_word   = load_word;
    next_load_strobe = 1'b0;
    unique case (state)
      PRFW_IDLE: begin
        next_count = '0;
        if (request) begin
          next_state = PRFW_INIT;
        end
      end
      PRFW_INIT: begin
        next_done  = 1'b0;
        next_count = count + 16'h0001;
        if (!request) begin
          next_state = PRFW_IDLE;
          next_count = '0;
        end else if (count >= 16'(INIT_CYCLES - 1)) begin
          next_state = PRFW_GAP;
          next_count = '0;
          next_ready = 1'b1;  // [R9]
        end
      end
      PRFW_GAP: begin
        next_count = count + 16'h0001;
        if (count >= 16'(READY_GAP_CYCLES - 4'h2)) begin
          next_state = PRFW_LOAD;  // [R14]
          next_count = '0;
        end
      end
      PRFW_LOAD: begin
        if (load_valid) begin
          next_load_word   = parallel_x16_load;  // [R11]
          next_load_strobe = 1'b1;
          next_count       = count + 16'h0001;
          if (count >= 16'(LOAD_WORDS - 1)) begin
            next_state = PRFW_DONE;
            next_count = '0;
            next_ready = 1'b0;
            next_done  = 1'b1;  // [R10]
          end
        end
      end
      PRFW_DONE: begin
        next_count = count + 16'h0001;
        if (!request) begin
          next_state = PRFW_IDLE;
          next_count = '0;
        end else if (count >= 16'(DROP_CYCLES - 4'h1)) begin
          next_state = PRFW_INIT;  // [R15]
          next_count = '0;
        end
      end
      default: begin
        next_state = PRFW_IDLE;
        next_count = '0;
        next_ready = 1'b0;
        next_done  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state          <= PRFW_IDLE;
      count          <= '0;
      reconfig_ready <= 1'b0;
      reconfig_done  <= 1'b0;
      load_word      <= '0;
      load_strobe    <= 1'b0;
    end else begin
      state          <= next_state;
      count          <= next_count;
      reconfig_ready <= next_ready;
      reconfig_done  <= next_done;
      load_word      <= next_load_word;
      load_strobe    <= next_load_strobe;
    end
  end

endmodule

//--- sim/prfw_monitor.sv
// checker for the freeze wrapper ports
// assumes bind onto prfw_wrapper, single clk_sys domain
`timescale 1ns/1ps
module prfw_monitor
  import prfw_pkg::*;
#(
  parameter int unsigned GLOBAL_NETS = 2
) (
  input wire logic                   clk_sys,
  input wire logic                   rstn,
  input wire logic                   freeze,
  input wire logic                   local_clock,
  input wire logic [GLOBAL_NETS-1:0] global_clock_net,
  input wire logic [MODE_W-1:0]      control_mode,
  input wire logic [LOAD_W-1:0]      parallel_x16_load,
  input wire logic                   gated_local_clock,
  input wire logic [MAX_GLOBALS-1:0] core_global_net,
  input wire logic [MODE_W-1:0]      core_mode,
  input wire logic [FRAMER_W-1:0]    core_framer,
  input wire logic [REGION_W-1:0]    data_out,
  input wire logic                   reconfig_ready,
  input wire logic                   reconfig_done,
  input wire logic [LOAD_W-1:0]      load_word,
  input wire logic                   load_strobe
);
  // ==========================================================================
  // properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // local clock rise seen while frozen, freeze still held one cycle on
  sequence framer_rise_seq;
    $rose(local_clock) && freeze ##1 freeze;
  endsequence
  mode_frozen_a: assert property (freeze |=> core_mode == 4'hF) else $error("mode not frozen");
  // only edges that ran out of reset carry the live value, the release edge still loads all ones
  mode_live_a: assert property (rstn && !freeze |=> core_mode == $past(control_mode))
    else $error("mode not live");
  framer_frozen_a: assert property (framer_rise_seq |=> core_framer == 4'hF) else $error("framer not frozen");
  clock_park_a: assert property (gated_local_clock == (freeze | local_clock)) else $error("clock not parked");
  output_safe_a: assert property (freeze |=> data_out == 16'h0000) else $error("output not safe");
  ready_excl_a: assert property (reconfig_ready |-> !reconfig_done) else $error("ready with done");
  done_follows_a: assert property ($fell(reconfig_ready) |-> reconfig_done) else $error("no done");
  word_load_a: assert property (load_strobe |-> load_word == $past(parallel_x16_load)) else $error("bad word");
  global_pass_a: assert property (core_global_net == MAX_GLOBALS'(global_clock_net)) else $error("net");
endmodule

bind prfw_wrapper prfw_monitor #(.GLOBAL_NETS(GLOBAL_NETS)) mon_u (.*);

//--- sim/prfw_host_model.sv
// host model: drives freeze, request and the 16-bit word stream
// assumes go is a one-cycle start pulse sampled on clk_sys
`timescale 1ns/1ps
module prfw_host_model #(
  parameter int unsigned WORDS = 4
) (
  input wire logic    clk_sys,
  input wire logic    go,
  input wire logic    slow,
  input wire logic    stay,
  input wire logic    reconfig_ready,
  input wire logic    reconfig_done,
  output logic        host_freeze,
  output logic        host_request,
  output logic [15:0] host_data,
  output logic        host_valid
);
  int n;
  // ==========================================================================
  // one reconfiguration per go pulse
  initial begin
    host_freeze = 1'b0;
    host_request = 1'b0;
    host_data = 16'h5A5A;
    host_valid = 1'b0;
    forever begin
      @(posedge clk_sys);
      if (go) begin
        host_freeze <= 1'b1;
        @(posedge clk_sys);
        host_request <= 1'b1;
        while (reconfig_ready !== 1'b1) @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
        for (n = 0; n < WORDS; n++) begin
          host_valid <= 1'b1;
          host_data <= 16'hA500 + 16'(n);
          @(posedge clk_sys);
          if (slow) begin
            host_valid <= 1'b0;
            host_data <= ~host_data; // released lines do not hold the word
            @(posedge clk_sys);
          end
        end
        host_valid <= 1'b0;
        host_data <= ~host_data;
        while (reconfig_done !== 1'b1) @(posedge clk_sys);
        repeat (20) if (stay && reconfig_done) @(posedge clk_sys); // stay breaks the drop deadline
        host_request <= 1'b0;
        @(posedge clk_sys);
        host_freeze <= 1'b0;
      end
    end
  end
endmodule

//--- sim/prfw_wrapper_tb.sv
// testbench for the freeze wrapper with a host model on the handshake
// assumes 200 MHz clk_sys and synchronous active-low rstn
`timescale 1ns/1ps
module prfw_wrapper_tb;
  import prfw_pkg::*;
  logic        clk_sys, rstn, tb_freeze, freeze, local_clock, async_clear, go, slow, stay;
  logic        pins_enable, pin_ready_user, pin_done_user, pin_request_user, pin_ready, pin_done;
  logic        host_freeze, host_request, host_valid, gated_local_clock, core_async_clear;
  logic        reconfig_ready, reconfig_done, load_strobe;
  logic [1:0]  global_clock_net;
  logic [5:0]  core_global_net;
  logic [3:0]  control_mode, framer_ctl, core_mode, core_framer;
  logic [15:0] core_out, data_out, load_word, host_data, n_word;
  int          n_fail, n_compared;
  assign freeze = host_freeze | tb_freeze;
  prfw_wrapper #(.LOAD_WORDS(4)) dut_u (.pin_request(host_request), .core_request(host_request),
    .parallel_x16_load(host_data), .load_valid(host_valid), .*);
  prfw_host_model #(.WORDS(4)) host_u (.*);
  // ==========================================================================
  // clock, compare and closing
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // each accepted word must be the next one sent
  // word counter restarts on each start pulse, one driver only
  always @(posedge clk_sys) begin
    if (go === 1'b1) begin
      n_word <= 16'h0000;
    end else if (load_strobe === 1'b1) begin
      chk(load_word, 16'hA500 + n_word);
      n_word <= n_word + 16'h0001;
    end
  end
  // ==========================================================================
  // scenarios
  task pulse_local;
    @(posedge clk_sys) local_clock <= 1'b1;
    @(posedge clk_sys) local_clock <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  task t_freeze;
    pulse_local;
    chk(core_mode, 16'h0005);
    chk(core_framer, 16'h000A);
    chk(data_out, 16'h1234);
    tb_freeze <= 1'b1;
    async_clear <= 1'b1;
    pulse_local;
    chk(core_mode, 16'h000F);
    chk(core_framer, 16'h000F);
    chk(data_out, 16'h0000);
    chk(gated_local_clock, 16'h0001);
    chk(core_global_net, 16'h0002);
    chk(core_async_clear, 16'h0001);
    tb_freeze <= 1'b0;
    $display("t_freeze finished");
  endtask
  task t_reconfig(input logic s, input logic st, input logic p);
    pins_enable <= p;
    slow <= s;
    stay <= st;
    go <= 1'b1;
    @(posedge clk_sys) go <= 1'b0;
    repeat (40) if (reconfig_done === 1'b1) @(posedge clk_sys);
    repeat (200) if (reconfig_done !== 1'b1) @(posedge clk_sys);
    chk(reconfig_done, 16'h0001);
    chk(reconfig_ready, 16'h0000);
    chk(pin_done, {15'h0000, p});
    repeat (30) @(posedge clk_sys);
    chk(n_word, 16'h0004);
    chk(reconfig_done, {15'h0000, !st});
    chk(reconfig_ready, 16'h0000);
    chk(freeze, 16'h0000);
    $display("t_reconfig finished");
  endtask
  task t_pins;
    pins_enable <= 1'b0;
    pin_done_user <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(core_async_clear, 16'h0001);
    chk(pin_ready, 16'h0001);
    chk(pin_done, 16'h0001);
    chk(pin_request_user, 16'h0000);
    pins_enable <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(pin_ready, 16'h0000);
    chk(pin_done, 16'h0000);
    $display("t_pins finished");
  endtask
  // ==========================================================================
  // main sequence and watchdog
  initial begin
    rstn = 1'b0;
    tb_freeze = 1'b0;
    local_clock = 1'b0;
    async_clear = 1'b0;
    {go, slow, stay, pins_enable, pin_done_user} = 5'h00;
    pin_ready_user = 1'b1;
    global_clock_net = 2'h2;
    control_mode = 4'h5;
    framer_ctl = 4'hA;
    core_out = 16'h1234;
    repeat (4) @(posedge clk_sys);
    chk(core_mode, 16'h000F);
    rstn <= 1'b1;
    t_freeze;
    t_reconfig(1'b0, 1'b0, 1'b0);
    t_reconfig(1'b1, 1'b0, 1'b1);
    t_reconfig(1'b0, 1'b1, 1'b1);
    t_pins;
    report_and_stop;
  end
  initial begin
    #20us;
    n_fail++;
    report_and_stop;
  end
endmodule
